// [hw/arc_pkg.sv]
// arc_pkg: constants shared by the converter result control block.
// assumes an 8-bit register port and a 10-bit successive approximation core.
package arc_pkg;
    localparam int RES_W = 10;
    localparam int AW    = 3;
    localparam int DW    = 8;

    // register offsets
    localparam logic [2:0] OFS_CHREF  = 3'h0; // channel_ref_select_reg
    localparam logic [2:0] OFS_CSA    = 3'h1; // control_status_a_reg
    localparam logic [2:0] OFS_CSB    = 3'h2; // control_status_b_reg
    localparam logic [2:0] OFS_TIMING = 3'h3; // timing_control_reg
    localparam logic [2:0] OFS_RES_LO = 3'h4; // result_low_byte
    localparam logic [2:0] OFS_RES_HI = 3'h5; // result_high_byte
    localparam logic [2:0] OFS_IRQ_ST = 3'h6;
    localparam logic [2:0] OFS_IRQ_MK = 3'h7;

    // channel_ref_select_reg fields
    localparam int REFSEL_LSB = 6;
    localparam int LADJ_BIT   = 5;
    localparam int CHLO_W     = 5;
    // control_status_a_reg fields
    localparam int EN_BIT     = 7;
    localparam int START_BIT  = 6;
    localparam int DONE_BIT   = 4;
    localparam int PRESC_W    = 3;
    // control_status_b_reg fields
    localparam int SUPOK_BIT  = 7;
    localparam int REFERENCE_OK_BIT  = 5;
    localparam int CHHI_BIT   = 3;
    // timing_control_reg fields
    localparam int TRK_LSB    = 6;
    localparam int TRK_W      = 2;
    localparam int SUT_W      = 5;

    // channels at or above this low code are differential pairs
    localparam logic [4:0] DIFF_CH_BASE = 5'h08;
    // offset-binary midscale; xor turns it into two's complement
    localparam logic [9:0] MID_CODE     = 10'h200;
    localparam logic [9:0] PRESC_BASE   = 10'h004;
    localparam logic [3:0] MSB_IDX      = 4'h9;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_WAIT_OK = 4'b0010,
        ST_TRACK   = 4'b0100,
        ST_CONVERT = 4'b1000
    } arc_state_e;
endpackage

// [hw/arc_format.sv]
// arc_format: places a 10-bit result in the low and high result bytes.
// assumes a stored code that is already in its final encoding.
`timescale 1ns/1ps
`default_nettype none
module arc_format (
    input  wire logic [9:0] code_i,
    input  wire logic       left_adjust_sel_i,
    output logic      [7:0] low_o,
    output logic      [7:0] high_o
);
    wire [7:0] left_hi  = code_i[9:2];
    wire [7:0] left_lo  = {code_i[1:0], 6'h00};
    wire [7:0] right_hi = {6'h00, code_i[9:8]};
    wire [7:0] right_lo = code_i[7:0];

    assign high_o = left_adjust_sel_i ? left_hi : right_hi;
    assign low_o  = left_adjust_sel_i ? left_lo : right_lo;
endmodule
`default_nettype wire

// [hw/arc_top.sv]
// arc_top: digital control of a 10-bit successive approximation converter:
// start gating, bit trial sequencing, result encoding, result registers.
// assumes the comparator, supply-ok and reference-ok arrive as async pins.
//
// How it works
// - completion sets done flag, updates result bytes unless a low byte read awaits its high read
// - single-ended gives unsigned code, zero to full
// - differential gives two's complement, 0x200 to 0x1FF
// - differential result sign bit is top bit
// - left adjust moves result to upper bits
// - start waits for supply-ok and reference-ok
// - start bit clears itself when conversion ends
// - same channel on both inputs is allowed
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module arc_top (
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    input  wire logic       CE_I,
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    output logic            IRQ_O,
    input  wire logic       ANALOG_SUPPLY_OK_I,
    input  wire logic       REFERENCE_OK_I,
    input  wire logic       COMP_I,
    output logic      [9:0] DAC_CODE_O,
    output logic            TRACK_O,
    output logic            DIFF_MODE_O,
    output logic      [5:0] CHANNEL_O,
    output logic      [1:0] REF_SEL_O,
    output logic            BUSY_O
);
    // pin synchronisers: first stage feeds only the second
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else if (CE_I) begin
            pin_s1_r <= {COMP_I, REFERENCE_OK_I, ANALOG_SUPPLY_OK_I};
            pin_s2_r <= pin_s1_r;
        end
    end
    wire analog_supply_ok = pin_s2_r[0];
    wire reference_ok     = pin_s2_r[1];
    wire comp_high        = pin_s2_r[2];

    // software-visible registers
    logic [7:0] chref_r;
    logic       enable_r;
    logic       start_r;
    logic       start_nxt;
    logic [2:0] presc_r;
    logic       channel_sel_high_r;
    logic [6:0] timing_r;
    logic       conv_done_flag_r;
    logic       irq_mask_r;
    logic       lock_r;
    logic [9:0] result_r;
    logic [7:0] rdata_r;

    wire wr_chref  = WR_I && (ADDR_I == arc_pkg::OFS_CHREF);
    wire wr_csa    = WR_I && (ADDR_I == arc_pkg::OFS_CSA);
    wire wr_csb    = WR_I && (ADDR_I == arc_pkg::OFS_CSB);
    wire wr_timing = WR_I && (ADDR_I == arc_pkg::OFS_TIMING);
    wire wr_irq_st = WR_I && (ADDR_I == arc_pkg::OFS_IRQ_ST);
    wire wr_irq_mk = WR_I && (ADDR_I == arc_pkg::OFS_IRQ_MK);
    wire rd_res_lo = RD_I && (ADDR_I == arc_pkg::OFS_RES_LO);
    wire rd_res_hi = RD_I && (ADDR_I == arc_pkg::OFS_RES_HI);

    wire       left_adjust_sel = chref_r[arc_pkg::LADJ_BIT];
    wire [4:0] channel_sel_low = chref_r[arc_pkg::CHLO_W-1:0];
    wire [1:0] reference_sel_field = chref_r[arc_pkg::REFSEL_LSB +: 2];
    wire [1:0] tracking_time_field = timing_r[arc_pkg::TRK_LSB-1 +: 2];
    wire [4:0] startup_time_field  = timing_r[arc_pkg::SUT_W-1:0];
    // same channel on both inputs is legal; the offset reading needs it
    wire diff_mode = channel_sel_high_r ||
                     (channel_sel_low >= arc_pkg::DIFF_CH_BASE);

    // sequencer
    arc_pkg::arc_state_e state_r;
    arc_pkg::arc_state_e state_nxt;
    logic [9:0] presc_cnt_r;
    logic [5:0] phase_cnt_r;
    logic [5:0] phase_cnt_nxt;
    logic       started_up_r;
    logic [9:0] code_r;
    logic [9:0] code_nxt;
    logic [3:0] bit_idx_r;
    logic [3:0] bit_idx_nxt;
    logic       conv_end;

    wire [9:0] presc_lim = (arc_pkg::PRESC_BASE << presc_r) - 10'h001;
    wire       tick      = (presc_cnt_r == presc_lim);
    wire       both_ok   = analog_supply_ok && reference_ok;
    wire [9:0] trial_bit = 10'h001 << bit_idx_r;
    wire [9:0] trial_nxt = 10'h001 << (bit_idx_r - 4'h1);
    wire [5:0] trk_len   = {4'h0, tracking_time_field} + 6'h01;
    wire [5:0] sut_len   = {1'b0, startup_time_field};
    wire       sut_done  = started_up_r || (phase_cnt_r >= sut_len);

    always_comb begin
        state_nxt     = state_r;
        phase_cnt_nxt = phase_cnt_r;
        code_nxt      = code_r;
        bit_idx_nxt   = bit_idx_r;
        conv_end      = 1'b0;
        case (state_r)
            arc_pkg::ST_IDLE: begin
                phase_cnt_nxt = 6'h00;
                if (enable_r && start_r) begin
                    state_nxt = arc_pkg::ST_WAIT_OK;
                end
            end
            arc_pkg::ST_WAIT_OK: begin
                // hold the start until both analog monitors report good
                if (tick && !sut_done) begin
                    phase_cnt_nxt = phase_cnt_r + 6'h01;
                end
                if (both_ok && sut_done) begin
                    state_nxt     = arc_pkg::ST_TRACK;
                    phase_cnt_nxt = 6'h00;
                end
            end
            arc_pkg::ST_TRACK: begin
                if (tick) begin
                    phase_cnt_nxt = phase_cnt_r + 6'h01;
                    if (phase_cnt_r + 6'h01 >= trk_len) begin
                        state_nxt   = arc_pkg::ST_CONVERT;
                        code_nxt    = arc_pkg::MID_CODE;
                        bit_idx_nxt = arc_pkg::MSB_IDX;
                    end
                end
            end
            arc_pkg::ST_CONVERT: begin
                if (tick) begin
                    // comparator low means the trial overshot the input
                    code_nxt = comp_high ? code_r : (code_r & ~trial_bit);
                    if (bit_idx_r == 4'h0) begin
                        conv_end  = 1'b1;
                        state_nxt = arc_pkg::ST_IDLE;
                    end else begin
                        code_nxt    = code_nxt | trial_nxt;
                        bit_idx_nxt = bit_idx_r - 4'h1;
                    end
                end
            end
            default: begin
                state_nxt = arc_pkg::ST_IDLE;
            end
        endcase
        if (!enable_r) begin
            state_nxt = arc_pkg::ST_IDLE;
        end
    end

    // single-ended code is the raw trial result; differential pairs are
    // offset binary around midscale, so flipping the top bit gives two's
    // complement and the 10-bit range itself saturates at the ends
    wire [9:0] final_code = code_nxt;
    wire [9:0] encoded    = diff_mode ? (final_code ^ arc_pkg::MID_CODE)
                                      : final_code;
    wire       result_sign_bit = encoded[9];

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_r      <= arc_pkg::ST_IDLE;
            presc_cnt_r  <= 10'h000;
            phase_cnt_r  <= 6'h00;
            code_r       <= 10'h000;
            bit_idx_r    <= 4'h0;
            started_up_r <= 1'b0;
        end else if (CE_I) begin
            state_r     <= state_nxt;
            phase_cnt_r <= phase_cnt_nxt;
            code_r      <= code_nxt;
            bit_idx_r   <= bit_idx_nxt;
            if (state_r == arc_pkg::ST_IDLE || tick) begin
                presc_cnt_r <= 10'h000;
            end else begin
                presc_cnt_r <= presc_cnt_r + 10'h001;
            end
            // start-up delay is paid once per enable
            if (!enable_r) begin
                started_up_r <= 1'b0;
            end else if (state_r == arc_pkg::ST_TRACK) begin
                started_up_r <= 1'b1;
            end
        end
    end

    // start bit: set by software, cleared by hardware at the end;
    // enable and start may arrive in one write, so use the new enable
    wire enable_nxt = wr_csa ? WDATA_I[arc_pkg::EN_BIT] : enable_r;
    always_comb begin
        start_nxt = start_r;
        if (wr_csa) begin
            start_nxt = WDATA_I[arc_pkg::START_BIT] | start_r;
        end
        if (conv_end || !enable_nxt) begin
            start_nxt = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            chref_r            <= 8'h00;
            enable_r           <= 1'b0;
            start_r            <= 1'b0;
            presc_r            <= 3'h0;
            channel_sel_high_r <= 1'b0;
            timing_r           <= 7'h00;
            irq_mask_r         <= 1'b0;
        end else if (CE_I) begin
            start_r <= start_nxt;
            if (wr_chref) begin
                chref_r <= WDATA_I;
            end
            if (wr_csa) begin
                enable_r <= WDATA_I[arc_pkg::EN_BIT];
                presc_r  <= WDATA_I[arc_pkg::PRESC_W-1:0];
            end
            if (wr_csb) begin
                channel_sel_high_r <= WDATA_I[arc_pkg::CHHI_BIT];
            end
            if (wr_timing) begin
                timing_r <= WDATA_I[6:0];
            end
            if (wr_irq_mk) begin
                irq_mask_r <= WDATA_I[0];
            end
        end
    end

    // done flag: write one to clear, a new completion wins the same cycle
    wire done_clr = (wr_csa && WDATA_I[arc_pkg::DONE_BIT]) ||
                    (wr_irq_st && WDATA_I[0]);
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            conv_done_flag_r <= 1'b0;
        end else if (CE_I) begin
            if (conv_end) begin
                conv_done_flag_r <= 1'b1;
            end else if (done_clr) begin
                conv_done_flag_r <= 1'b0;
            end
        end
    end

    // result pair stays coherent between a low read and a high read, unless a completion lands in the low read's cycle
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lock_r   <= 1'b0;
            result_r <= 10'h000;
        end else if (CE_I) begin
            if (rd_res_hi) begin
                lock_r <= 1'b0;
            end else if (rd_res_lo) begin
                lock_r <= 1'b1;
            end
            if (conv_end && !lock_r) begin
                result_r <= {result_sign_bit, encoded[8:0]};
            end
        end
    end

    // alignment is applied at read time so a change shows at once
    wire [7:0] result_low_byte;
    wire [7:0] result_high_byte;
    arc_format u_format (
        .code_i            (result_r),
        .left_adjust_sel_i (left_adjust_sel),
        .low_o             (result_low_byte),
        .high_o            (result_high_byte)
    );

    wire [7:0] csa_rd = {enable_r, start_r, 1'b0, conv_done_flag_r,
                         1'b0, presc_r};
    wire [7:0] csb_rd = {analog_supply_ok, 1'b0, reference_ok, 1'b0,
                         channel_sel_high_r, 3'h0};
    logic [7:0] rd_mux;
    always_comb begin
        case (ADDR_I)
            arc_pkg::OFS_CHREF:  rd_mux = chref_r;
            arc_pkg::OFS_CSA:    rd_mux = csa_rd;
            arc_pkg::OFS_CSB:    rd_mux = csb_rd;
            arc_pkg::OFS_TIMING: rd_mux = {1'b0, timing_r};
            arc_pkg::OFS_RES_LO: rd_mux = result_low_byte;
            arc_pkg::OFS_RES_HI: rd_mux = result_high_byte;
            arc_pkg::OFS_IRQ_ST: rd_mux = {7'h00, conv_done_flag_r};
            arc_pkg::OFS_IRQ_MK: rd_mux = {7'h00, irq_mask_r};
            default:             rd_mux = 8'h00;
        endcase
    end

    // outputs, all registered
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_r     <= 8'h00;
            IRQ_O       <= 1'b0;
            DAC_CODE_O  <= 10'h000;
            TRACK_O     <= 1'b0;
            DIFF_MODE_O <= 1'b0;
            CHANNEL_O   <= 6'h00;
            REF_SEL_O   <= 2'h0;
            BUSY_O      <= 1'b0;
        end else if (CE_I) begin
            rdata_r     <= RD_I ? rd_mux : 8'h00;
            IRQ_O       <= conv_done_flag_r && irq_mask_r;
            DAC_CODE_O  <= code_r;
            TRACK_O     <= (state_r == arc_pkg::ST_TRACK);
            DIFF_MODE_O <= diff_mode;
            CHANNEL_O   <= {channel_sel_high_r, channel_sel_low};
            REF_SEL_O   <= reference_sel_field;
            BUSY_O      <= (state_r != arc_pkg::ST_IDLE);
        end
    end
    assign RDATA_O = rdata_r;
endmodule
`default_nettype wire

// [verification/arc_analog_model.sv]
// arc_analog_model: ideal comparator standing for the analog inputs.
// assumes level and dac code share one 10-bit code scale.
`timescale 1ns/1ps
`default_nettype none
module arc_analog_model (
    input  wire logic [9:0] dac_code_i,
    input  wire logic [9:0] level_i,
    output logic            comp_o
);
    // continuous, as a real comparator; the design resynchronises it
    assign comp_o = (level_i >= dac_code_i);
endmodule
`default_nettype wire

// [verification/arc_properties.sv]
// arc_properties: port-level checks of the converter control block.
// assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module arc_checker (
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    input  wire logic       CE_I,
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic [7:0] RDATA_O,
    input  wire logic       IRQ_O,
    input  wire logic       ANALOG_SUPPLY_OK_I,
    input  wire logic       REFERENCE_OK_I,
    input  wire logic [9:0] DAC_CODE_O,
    input  wire logic       TRACK_O,
    input  wire logic       DIFF_MODE_O,
    input  wire logic [5:0] CHANNEL_O,
    input  wire logic       BUSY_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    logic start_w;
    logic ok_w;
    assign start_w = CE_I && WR_I && ADDR_I == arc_pkg::OFS_CSA
                     && WDATA_I[arc_pkg::EN_BIT] && WDATA_I[arc_pkg::START_BIT];
    assign ok_w = ANALOG_SUPPLY_OK_I && REFERENCE_OK_I;
    sequence s_start;
        start_w && !BUSY_O;
    endsequence
    sequence s_busy_soon;
        ##[1:3] BUSY_O;
    endsequence
    property p_chan;
        logic [4:0] d;
        (CE_I && WR_I && ADDR_I == arc_pkg::OFS_CHREF, d = WDATA_I[4:0])
            |-> ##2 CHANNEL_O[4:0] == d;
    endproperty
    rdata_idle_a:
        assert property ($past(CE_I) && !$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not idle");
    start_busy_a:
        assert property (s_start |-> s_busy_soon)
        else $error("start not taken");
    busy_cause_a:
        assert property ($rose(BUSY_O) |-> $past(start_w, 3))
        else $error("busy without start");
    track_gate_a:
        assert property ($rose(TRACK_O) |-> $past(ok_w, 4))
        else $error("tracking before supply and reference ok");
    track_busy_a:
        assert property (TRACK_O |-> BUSY_O)
        else $error("tracking while idle");
    first_trial_a:
        assert property ($fell(TRACK_O) && BUSY_O
                         |-> ##[0:3] DAC_CODE_O == 10'h200)
        else $error("first trial not midscale");
    diff_mode_a:
        assert property (DIFF_MODE_O == (CHANNEL_O[5]
                         || CHANNEL_O[4:0] >= arc_pkg::DIFF_CH_BASE))
        else $error("differential mode wrong");
    chan_follow_a:
        assert property (p_chan)
        else $error("channel not applied");
    irq_mask_a:
        assert property (CE_I && WR_I && ADDR_I == arc_pkg::OFS_IRQ_MK
                         && !WDATA_I[0] |-> ##2 !IRQ_O)
        else $error("masked interrupt high");
endmodule
bind arc_top arc_checker u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .IRQ_O(IRQ_O), .ANALOG_SUPPLY_OK_I(ANALOG_SUPPLY_OK_I),
    .REFERENCE_OK_I(REFERENCE_OK_I), .DAC_CODE_O(DAC_CODE_O),
    .TRACK_O(TRACK_O), .DIFF_MODE_O(DIFF_MODE_O), .CHANNEL_O(CHANNEL_O),
    .BUSY_O(BUSY_O));
`default_nettype wire

// [verification/testbench.sv]
// testbench: register-level tests of the converter control block.
// assumes the ideal comparator model in front of the comparator pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk, rst, we, re, sok, rok, comp, irq, track, diff, busy, ce;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [9:0] level, dac;
    logic [5:0] chan;
    logic [1:0] rsel;
    int         error_cnt, comparisons;

    arc_top uut (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(we), .RD_I(re), .RDATA_O(rdata), .IRQ_O(irq),
        .ANALOG_SUPPLY_OK_I(sok), .REFERENCE_OK_I(rok), .COMP_I(comp),
        .DAC_CODE_O(dac), .TRACK_O(track), .DIFF_MODE_O(diff),
        .CHANNEL_O(chan), .REF_SEL_O(rsel), .BUSY_O(busy));
    arc_analog_model u_an (.dac_code_i(dac), .level_i(level), .comp_o(comp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run;
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk({2'b0, v}, {2'b0, e});
    endtask

    task automatic res(input logic [7:0] lo, input logic [7:0] hi);
        rdc(arc_pkg::OFS_RES_LO, lo);
        rdc(arc_pkg::OFS_RES_HI, hi);
    endtask

    task automatic wait_done;
        logic [7:0] v;
        int         n;
        v = 8'h40;
        n = 0;
        while (v[6] && n < 300) begin
            rd(arc_pkg::OFS_CSA, v);
            n++;
        end
        chk({9'h0, v[6]}, 10'h000);
        chk({9'h0, v[4]}, 10'h001);
    endtask

    // start also clears a pending done flag by write-one
    task automatic conv(input logic [9:0] lv);
        @(posedge clk);
        level <= lv;
        wr(arc_pkg::OFS_CSA, 8'hd0);
        wait_done();
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        we = 1'b0;
        re = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        sok = 1'b1;
        rok = 1'b1;
        level = 10'h000;
        error_cnt = 0;
        comparisons = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rdc(i[2:0], (i == 2) ? 8'ha0 : 8'h00);
        end
        wr(arc_pkg::OFS_CSB, 8'hff);
        rdc(arc_pkg::OFS_CSB, 8'ha8);
        wr(arc_pkg::OFS_CSB, 8'h00);
        wr(arc_pkg::OFS_TIMING, 8'h00);
        wr(arc_pkg::OFS_IRQ_MK, 8'h01);
        wr(arc_pkg::OFS_CHREF, 8'h00);
        conv(10'h3ff);
        chk({9'h0, diff}, 10'h000);
        res(8'hff, 8'h03);
        chk({9'h0, irq}, 10'h001);
        rd(arc_pkg::OFS_RES_LO, d);
        conv(10'h000);
        rdc(arc_pkg::OFS_RES_HI, 8'h03);
        res(8'hff, 8'h03);
        wr(arc_pkg::OFS_IRQ_ST, 8'h01);
        rdc(arc_pkg::OFS_IRQ_ST, 8'h00);
        chk({9'h0, irq}, 10'h000);
        wr(arc_pkg::OFS_CHREF, 8'h20);
        conv(10'h001);
        res(8'h40, 8'h00);
        wr(arc_pkg::OFS_CHREF, 8'hed);
        conv(10'h070);
        chk({9'h0, diff}, 10'h001);
        res(8'h00, 8'h9c);
        wr(arc_pkg::OFS_CHREF, 8'hcd);
        res(8'h70, 8'h02);
        conv(10'h3ff);
        res(8'hff, 8'h01);
        conv(10'h000);
        res(8'h00, 8'h02);
        wr(arc_pkg::OFS_IRQ_MK, 8'h00);
        rdc(arc_pkg::OFS_IRQ_ST, 8'h01);
        chk({9'h0, irq}, 10'h000);
        wr(arc_pkg::OFS_IRQ_MK, 8'h01);
        rdc(arc_pkg::OFS_IRQ_MK, 8'h01);
        chk({9'h0, irq}, 10'h001);
        // a write with the clock enable low must leave the mask alone
        @(posedge clk);
        ce <= 1'b0;
        wr(arc_pkg::OFS_IRQ_MK, 8'h00);
        ce <= 1'b1;
        rdc(arc_pkg::OFS_IRQ_MK, 8'h01);
        chk({9'h0, irq}, 10'h001);
        wr(arc_pkg::OFS_CSB, 8'h08);
        wr(arc_pkg::OFS_CHREF, 8'hc9);
        conv(10'h2f2);
        chk({8'h0, rsel}, 10'h003);
        chk({4'h0, chan}, 10'h029);
        chk({9'h0, diff}, 10'h001);
        res(8'hf2, 8'h00);
        wr(arc_pkg::OFS_CSB, 8'h00);
        wr(arc_pkg::OFS_CHREF, 8'hc8);
        conv(10'h201);
        res(8'h01, 8'h00);
        // re-enable with start-up and tracking counts that are not zero
        wr(arc_pkg::OFS_CSA, 8'h00);
        wr(arc_pkg::OFS_TIMING, 8'h62);
        rdc(arc_pkg::OFS_TIMING, 8'h62);
        wr(arc_pkg::OFS_CHREF, 8'h00);
        conv(10'h155);
        res(8'h55, 8'h01);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            sok <= i[0];
            rok <= !i[0];
            wr(arc_pkg::OFS_CSA, 8'hd0);
            repeat (60) @(posedge clk);
            rdc(arc_pkg::OFS_CSA, 8'hc0);
            chk({9'h0, track}, 10'h000);
            @(posedge clk);
            sok <= 1'b1;
            rok <= 1'b1;
            wait_done();
        end
        complete_run();
    end
endmodule
`default_nettype wire
